// ---- logic/sbt_timer.sv ----
// Purpose: Sixteen-bit timer/counter with prescaler and buffered wide access
// Assumes: clk is the system clock; all inputs synchronous to clk except ext_clk_in
// Notes: Asynchronous counter mode samples the pin on clk; there is no second clock domain
// Function
// - 16-bit count, reached as low and high 8-bit registers.
// - Control bit 7 selects buffered 16-bit or independent 8-bit access.
// - Bits 6,3 pick which timer pair feeds each capture/compare channel.
// - Bits 5-4 select prescale 1:1, 1:2, 1:4 or 1:8.
// - External clock synchronized when bit 2 clear, raw when set.
// - With internal clock the sync bit is ignored.
// - External source counts rising edges, first one after a low level is seen.
// - Internal source advances each instruction cycle, system clock over four.
// - Bit 0 runs or halts counting; halted value is kept.
// - Oscillator enabled forces its pins to inputs, reading zero.
// - Wide mode: low-byte read snapshots live high byte into buffer.
// - Wide mode: high write goes to buffer; low write loads both.
// - Wide mode: high byte only reached through buffer.
// - Low-byte write clears prescaler; high-byte write does not.
// - Counter wraps FFFFh to 0000h and latches an overflow flag.
// - Interrupt request follows flag only while its enable is set.
// - Compare event code 1011 resets count, not in async mode, no flag.
// - Software count write wins over a coincident event reset.
`timescale 1ns/1ns
module sbt_timer
    import sbt_pkg::*;
#(
    parameter int NUM_CHANNELS = 5
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External count clock, compare events and oscillator pins
    input wire logic ext_clk_in,
    input wire logic [NUM_CHANNELS-1:0] event_trigger,
    input wire logic [NUM_CHANNELS*4-1:0] compare_mode_code,
    input wire logic [1:0] osc_pin_in,
    // Outputs
    output logic [NUM_CHANNELS-1:0] channel_uses_this,
    output logic overflow_irq,
    output logic [1:0] osc_pin_read,
    output logic osc_pins_input
);
    // Elaboration check: channel map covers five channels
    if (NUM_CHANNELS != 5)
        $error("sbt_timer serves exactly five channels");

    // The two-bit divider serves only a divide-by-four instruction clock
    if (SBT_INSTR_DIV != 4)
        $error("sbt_timer needs a divide-by-four instruction clock");

    // Edge arming state for the external source
    typedef enum logic [1:0] {SBT_WAIT_LOW = 2'b00, SBT_ARMED = 2'b01} sbt_edge_type;

    logic [7:0] control, next_control;
    logic [15:0] count, next_count;
    logic [7:0] hi_buffer, next_hi_buffer;
    logic [2:0] prescale, next_prescale;
    logic [1:0] div4, next_div4;
    logic ovf_flag, next_ovf_flag;
    logic ovf_ie, next_ovf_ie;
    logic osc_enable, next_osc_enable;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic ext_s1, ext_s2, ext_s3, ext_raw_d, ext_raw_d2;
    sbt_edge_type edge_state, next_edge_state;
    logic [NUM_CHANNELS-1:0] next_channel_uses_this;
    logic [1:0] next_osc_pin_read;
    logic next_overflow_irq;

    logic setup;
    logic wr_lo, wr_hi, wr_ctl, rd_lo;
    logic ext_level, ext_prev, rise, fall;
    logic tick, ps_done, event_hit;
    logic [1:0] src;
    logic [2:0] ps_mask;

    // Setup phase decode; slave answers with zero wait states
    assign setup = psel && !penable;
    assign wr_lo = setup && pwrite && paddr == SBT_OFF_COUNT_LO;
    assign wr_hi = setup && pwrite && paddr == SBT_OFF_COUNT_HI;
    assign wr_ctl = setup && pwrite && paddr == SBT_OFF_CONTROL;
    assign rd_lo = setup && !pwrite && paddr == SBT_OFF_COUNT_LO;

    // Source selection; the raw path skips the synchroniser for asynchronous counter mode
    // Both paths compare a sample with the one a clock older, so each pin edge ticks once
    assign ext_level = control[SBT_B_NOSYNC] ? ext_raw_d : ext_s2;
    assign ext_prev = control[SBT_B_NOSYNC] ? ext_raw_d2 : ext_s3;
    assign rise = ext_level && !ext_prev;
    assign fall = !ext_level;
    assign src = {control[SBT_B_SRC_HI], control[SBT_B_SRC_LO]};
    assign ps_mask = (3'h1 << control[SBT_B_PS_HI:SBT_B_PS_LO]) - 3'h1;

    // Count tick: instruction cycle or armed external rising edge
    always_comb
    begin
        if (control[SBT_B_CLKSRC])
            tick = rise && edge_state == SBT_ARMED;
        else
            tick = div4 == 2'(SBT_INSTR_DIV - 1);
    end

    // A prescale wrap is the only thing that advances the count
    assign ps_done = tick && control[SBT_B_RUN] && ((prescale & ps_mask) == ps_mask);

    // Event reset is inert in asynchronous counter mode
    always_comb
    begin
        event_hit = 1'b0;
        for (int i = 0; i < NUM_CHANNELS; i++)
            if (event_trigger[i] && channel_uses_this[i]
                && compare_mode_code[i*4 +: 4] == SBT_CMP_EVENT)
                event_hit = 1'b1;
        if (control[SBT_B_CLKSRC] && control[SBT_B_NOSYNC])
            event_hit = 1'b0;
        // A coincident software write to either count byte discards the reset
        if (wr_lo || wr_hi)
            event_hit = 1'b0;
    end

    // Register, counter and bus next-state logic
    always_comb
    begin
        next_control = control;
        next_count = count;
        next_hi_buffer = hi_buffer;
        next_prescale = prescale;
        next_div4 = div4 + 2'h1;
        next_ovf_flag = ovf_flag;
        next_ovf_ie = ovf_ie;
        next_osc_enable = osc_enable;
        next_prdata = 32'h0000_0000;
        next_pready = setup;
        next_pslverr = 1'b0;
        next_edge_state = edge_state;
        // Edge arming: a low level must be seen before a rise counts
        if (!control[SBT_B_CLKSRC] || !control[SBT_B_RUN])
            next_edge_state = SBT_WAIT_LOW;
        else if (fall)
            next_edge_state = SBT_ARMED;
        // Prescaler, then counter; only the wrap sets the flag, never an event reset
        if (tick && control[SBT_B_RUN])
            next_prescale = prescale + 3'h1;
        if (ps_done)
        begin
            next_count = count + 16'h0001;
            next_prescale = 3'h0;
            if (count == SBT_COUNT_MAX)
                next_ovf_flag = 1'b1;
        end
        if (event_hit)
            next_count = SBT_COUNT_RST;
        // Read mux; unmapped addresses answer with an error and change nothing
        if (setup)
        begin
            unique case (paddr)
                SBT_OFF_CONTROL:
                    next_prdata = {24'h000000, control};
                SBT_OFF_COUNT_LO:
                    next_prdata = {24'h000000, count[7:0]};
                SBT_OFF_COUNT_HI:
                    next_prdata = {24'h000000,
                        control[SBT_B_WIDE] ? hi_buffer : count[15:8]};
                SBT_OFF_STATUS:
                    next_prdata = {30'h0, ovf_ie, ovf_flag};
                SBT_OFF_OSC:
                    next_prdata = {31'h0, osc_enable};
                default:
                    next_pslverr = 1'b1;
            endcase
        end
        if (rd_lo && control[SBT_B_WIDE])
            next_hi_buffer = count[15:8];
        if (wr_ctl)
            next_control = pwdata[7:0];
        if (setup && pwrite && paddr == SBT_OFF_STATUS)
        begin
            next_ovf_ie = pwdata[SBT_B_OVF_IE];
            if (!pwdata[SBT_B_OVF] && !(ps_done && count == SBT_COUNT_MAX))
                next_ovf_flag = 1'b0;
        end
        if (setup && pwrite && paddr == SBT_OFF_OSC)
            next_osc_enable = pwdata[0];
        if (wr_hi)
        begin
            if (control[SBT_B_WIDE])
                next_hi_buffer = pwdata[7:0];
            else
                next_count[15:8] = pwdata[7:0];
        end
        if (wr_lo)
        begin
            next_count[7:0] = pwdata[7:0];
            if (control[SBT_B_WIDE])
                next_count[15:8] = hi_buffer;
            next_prescale = 3'h0;
        end
    end

    // Channel map, interrupt and pin outputs
    // Irq and pin outputs follow the next state so they do not lag a write; the channel map follows current control
    always_comb
    begin
        next_channel_uses_this = '0;
        for (int i = 0; i < NUM_CHANNELS; i++)
            next_channel_uses_this[i] = (src == SBT_SRC_ALL)
                || (src == SBT_SRC_3TO5 && i >= 2)
                || (src == SBT_SRC_2TO5 && i >= 1);
        next_overflow_irq = next_ovf_flag && next_ovf_ie;
        next_osc_pin_read = next_osc_enable ? 2'h0 : osc_pin_in;
    end

    // Pin samplers; ext_s1 feeds only ext_s2, the raw pair serves asynchronous mode
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
            ext_raw_d <= 1'b0;
            ext_raw_d2 <= 1'b0;
        end
        else
        begin
            ext_s1 <= ext_clk_in;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            ext_raw_d <= ext_clk_in;
            ext_raw_d2 <= ext_raw_d;
        end
    end

    // Bus answer registers; one access cycle per transfer, no wait states
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Timer state registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            control <= SBT_CONTROL_RST;
            count <= SBT_COUNT_RST;
            hi_buffer <= 8'h00;
            prescale <= 3'h0;
            div4 <= 2'h0;
            ovf_flag <= 1'b0;
            ovf_ie <= 1'b0;
            osc_enable <= 1'b0;
            edge_state <= SBT_WAIT_LOW;
        end
        else
        begin
            control <= next_control;
            count <= next_count;
            hi_buffer <= next_hi_buffer;
            prescale <= next_prescale;
            div4 <= next_div4;
            ovf_flag <= next_ovf_flag;
            ovf_ie <= next_ovf_ie;
            osc_enable <= next_osc_enable;
            edge_state <= next_edge_state;
        end
    end

    // Output registers; every top-level output leaves from a flip-flop
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            channel_uses_this <= '0;
            overflow_irq <= 1'b0;
            osc_pin_read <= 2'h0;
            osc_pins_input <= 1'b0;
        end
        else
        begin
            channel_uses_this <= next_channel_uses_this;
            overflow_irq <= next_overflow_irq;
            osc_pin_read <= next_osc_pin_read;
            osc_pins_input <= next_osc_enable;
        end
    end
endmodule

// ---- logic/sbt_pkg.sv ----
// Purpose: Constants for the sixteen-bit timer/counter block
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes: Register offsets are byte addresses
package sbt_pkg;
    // Register byte offsets
    localparam logic [7:0] SBT_OFF_CONTROL = 8'h00;
    localparam logic [7:0] SBT_OFF_COUNT_LO = 8'h04;
    localparam logic [7:0] SBT_OFF_COUNT_HI = 8'h08;
    localparam logic [7:0] SBT_OFF_STATUS = 8'h0C;
    localparam logic [7:0] SBT_OFF_OSC = 8'h10;
    // Control field positions
    localparam int SBT_B_RUN = 0;
    localparam int SBT_B_CLKSRC = 1;
    localparam int SBT_B_NOSYNC = 2;
    localparam int SBT_B_SRC_LO = 3;
    localparam int SBT_B_PS_LO = 4;
    localparam int SBT_B_PS_HI = 5;
    localparam int SBT_B_SRC_HI = 6;
    localparam int SBT_B_WIDE = 7;
    // Status and enable bit positions
    localparam int SBT_B_OVF = 0;
    localparam int SBT_B_OVF_IE = 1;
    // Reset values
    localparam logic [7:0] SBT_CONTROL_RST = 8'h00;
    localparam logic [15:0] SBT_COUNT_RST = 16'h0000;
    localparam logic [15:0] SBT_COUNT_MAX = 16'hFFFF;
    // Instruction clock is system clock divided by this
    localparam int SBT_INSTR_DIV = 4;
    // Special event trigger compare mode code
    localparam logic [3:0] SBT_CMP_EVENT = 4'hB;
    // Channel source codes
    localparam logic [1:0] SBT_SRC_ALL = 2'h3;
    localparam logic [1:0] SBT_SRC_3TO5 = 2'h2;
    localparam logic [1:0] SBT_SRC_2TO5 = 2'h1;
endpackage

// ---- dv/sbt_timer_sva.sv ----
// Purpose: Port-level checker for sbt_timer
// Assumes: Sees only top-level ports; settings taken at APB setup
// Notes: Register bits are mirrored from bus writes
`timescale 1ns/1ns
module sbt_timer_sva
    import sbt_pkg::*;
#(
    parameter int NUM_CHANNELS = 5
)
(
    // Clock, reset and APB
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Block outputs
    input wire logic [NUM_CHANNELS-1:0] channel_uses_this,
    input wire logic overflow_irq,
    input wire logic [1:0] osc_pin_read,
    input wire logic osc_pins_input
);
    logic [9:0] shd, next_shd, shd_d;
    logic wr;
    logic [4:0] map;
    // Mirror of control, irq enable and oscillator enable
    always_comb
    begin
        wr = psel && !penable && pwrite;
        next_shd[7:0] = (wr && paddr == SBT_OFF_CONTROL) ? pwdata[7:0] : shd[7:0];
        next_shd[8] = (wr && paddr == SBT_OFF_STATUS) ? pwdata[SBT_B_OVF_IE] : shd[8];
        next_shd[9] = (wr && paddr == SBT_OFF_OSC) ? pwdata[0] : shd[9];
        map = {shd[6], shd[3]} == 2'h3 ? 5'h1F : {shd[6], shd[3]} == 2'h2 ? 5'h1C :
            {shd[6], shd[3]} == 2'h1 ? 5'h1E : 5'h00;
    end
    // Delayed copy lets outputs settle a cycle before they are judged
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            shd <= 10'h000;
            shd_d <= 10'h000;
        end
        else
        begin
            shd <= next_shd;
            shd_d <= shd;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_one_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_unmapped: assert property (pready |-> pslverr ==
        (paddr > SBT_OFF_OSC || paddr[1:0] != 2'h0))
        else $error("pslverr wrong for address");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside access");
    a_read_idle_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero when idle");
    a_channel_map: assert property (shd == shd_d |-> channel_uses_this == map)
        else $error("channel sources wrong");
    a_irq_masked: assert property (!shd[8] && !shd_d[8] |-> !overflow_irq)
        else $error("irq while masked");
    a_osc_forces_input: assert property (shd[9] == shd_d[9] |-> osc_pins_input == shd[9])
        else $error("pin direction wrong");
    a_osc_read_zero: assert property (osc_pins_input |-> osc_pin_read == 2'h0)
        else $error("pin read not zero");
    c_overflow: cover property ($rose(overflow_irq));
    c_osc: cover property ($rose(osc_pins_input));
    c_unmapped: cover property (pready && pslverr);
endmodule
bind sbt_timer sbt_timer_sva #(.NUM_CHANNELS(NUM_CHANNELS)) i_sbt_timer_sva (.clk(clk),
    .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .channel_uses_this(channel_uses_this), .overflow_irq(overflow_irq),
    .osc_pin_read(osc_pin_read), .osc_pins_input(osc_pins_input));

// ---- dv/sbt_ext_src.sv ----
// Purpose: Far-side model of the external count clock pin
// Assumes: Bursts are gated by run
// Notes: Rests low between bursts, so each burst starts after a low level
`timescale 1ns/1ns
module sbt_ext_src
#(
    parameter int HALF = 5
)
(
    // Clock and burst gate
    input wire logic clk,
    input wire logic run,
    // Pin drive
    output logic ext_clk_in = 1'b0
);
    int cnt = 0;
    // Toggle every HALF system clocks inside a burst
    always @(posedge clk)
    begin
        cnt <= (run && cnt < HALF - 1) ? cnt + 1 : 0;
        if (!run)
            ext_clk_in <= 1'b0;
        else if (cnt == HALF - 1)
            ext_clk_in <= !ext_clk_in;
    end
endmodule

// ---- dv/test_sbt_timer.sv ----
// Purpose: Self-checking bench for sbt_timer
// Assumes: APB answers in the access cycle
// Notes: Count checks allow two ticks of slack for divider phase
`timescale 1ns/1ns
module test_sbt_timer
    import sbt_pkg::*;
;
    logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run_ext = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, ext_clk_in, overflow_irq, osc_pins_input;
    logic [4:0] ev = 5'h00, chan;
    logic [19:0] cmc = 20'h00000;
    logic [1:0] opin = 2'h0, oread;
    logic [15:0] v;
    logic [32:0] expq[$];
    int fail_count = 0, n_tests = 0, cyc = 0;
    always #20 clk = !clk;
    sbt_timer #(.NUM_CHANNELS(5)) i_sbt_timer (.clk(clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_clk_in(ext_clk_in), .event_trigger(ev),
        .compare_mode_code(cmc), .osc_pin_in(opin), .channel_uses_this(chan),
        .overflow_irq(overflow_irq), .osc_pin_read(oread), .osc_pins_input(osc_pins_input));
    sbt_ext_src #(.HALF(5)) i_sbt_ext_src (.clk(clk), .run(run_ext), .ext_clk_in(ext_clk_in));
    task automatic stop_test;
        $display("Counts: %0d compared, %0d failed", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic e, input logic [32:0] x);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (e)
            expq.push_back(x);
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // An idle edge keeps psel from falling and rising in one step
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0, 33'h0);
    endtask
    task automatic rx(input logic [7:0] a, input logic [32:0] x);
        apb(1'b0, a, 32'h0, 1'b1, x);
    endtask
    // Count from zero for 40 increments' worth of clocks
    task automatic run_cnt(input logic [7:0] c, input int per);
        int n;
        wr(SBT_OFF_COUNT_LO, 32'h0);
        wr(SBT_OFF_CONTROL, {24'h0, c | 8'h01});
        repeat (40 * per) @(posedge clk);
        wr(SBT_OFF_CONTROL, {24'h0, c});
        apb(1'b0, SBT_OFF_COUNT_LO, 32'h0, 1'b0, 33'h0);
        n = int'(rd[7:0]);
        check(33'(n >= 38 && n <= 42), 33'h1);
    endtask
    // Read answers are matched against the oldest note
    always @(posedge clk)
        if (pready === 1'b1 && pwrite === 1'b0 && expq.size() > 0)
            check({pslverr, prdata}, expq.pop_front());
    // A hang counts as a mismatch
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fail_count++;
            stop_test();
        end
    end
    initial
    begin
        void'($urandom(32'h79CAC67E));
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rx(SBT_OFF_CONTROL, 33'h0);
        rx(8'h14, {1'b1, 32'h0});
        $display("Test reset done");
        for (int s = 0; s < 4; s++)
        begin
            wr(SBT_OFF_CONTROL, {25'h0, s[1], 2'h0, s[0], 3'h0});
            repeat (2) @(posedge clk);
            check(33'(chan), s == 3 ? 33'h1F : s == 2 ? 33'h1C : s == 1 ? 33'h1E : 33'h0);
        end
        $display("Test channels done");
        for (int p = 0; p < 4; p++)
            run_cnt({2'h0, p[1:0], 1'b0, 1'($urandom), 2'h0}, 4 << p);
        run_ext <= 1'b1;
        run_cnt(8'h02, 10);
        run_cnt(8'h06, 10);
        run_ext <= 1'b0;
        $display("Test counting done");
        v = 16'($urandom);
        wr(SBT_OFF_CONTROL, 32'h80);
        wr(SBT_OFF_COUNT_HI, {24'h0, v[15:8]});
        rx(SBT_OFF_COUNT_HI, {25'h0, v[15:8]});
        wr(SBT_OFF_COUNT_LO, {24'h0, v[7:0]});
        wr(SBT_OFF_COUNT_HI, {24'h0, ~v[15:8]});
        rx(SBT_OFF_COUNT_LO, {25'h0, v[7:0]});
        rx(SBT_OFF_COUNT_HI, {25'h0, v[15:8]});
        wr(SBT_OFF_CONTROL, 32'h0);
        rx(SBT_OFF_COUNT_HI, {25'h0, v[15:8]});
        $display("Test wide access done");
        wr(SBT_OFF_COUNT_HI, 32'hFF);
        wr(SBT_OFF_COUNT_LO, 32'hFE);
        wr(SBT_OFF_STATUS, 32'h2);
        wr(SBT_OFF_CONTROL, 32'h1);
        repeat (20) @(posedge clk);
        wr(SBT_OFF_CONTROL, 32'h0);
        rx(SBT_OFF_COUNT_HI, 33'h0);
        rx(SBT_OFF_STATUS, 33'h3);
        check(33'(overflow_irq), 33'h1);
        wr(SBT_OFF_STATUS, 32'h1);
        @(posedge clk);
        check(33'(overflow_irq), 33'h0);
        wr(SBT_OFF_STATUS, 32'h0);
        rx(SBT_OFF_STATUS, 33'h0);
        $display("Test overflow done");
        cmc <= 20'h0000B;
        wr(SBT_OFF_CONTROL, 32'h48);
        wr(SBT_OFF_COUNT_LO, 32'h55);
        ev <= 5'h01;
        @(posedge clk);
        ev <= 5'h00;
        rx(SBT_OFF_COUNT_LO, 33'h0);
        rx(SBT_OFF_STATUS, 33'h0);
        wr(SBT_OFF_COUNT_HI, 32'h3C);
        ev <= 5'h01;
        fork
            @(posedge clk) ev <= 5'h00;
        join_none
        wr(SBT_OFF_COUNT_LO, 32'h77);
        rx(SBT_OFF_COUNT_LO, 33'h77);
        rx(SBT_OFF_COUNT_HI, 33'h3C);
        $display("Test event reset done");
        opin <= 2'($urandom) | 2'h1;
        wr(SBT_OFF_OSC, 32'h1);
        repeat (2) @(posedge clk);
        check(33'(oread), 33'h0);
        check(33'(osc_pins_input), 33'h1);
        wr(SBT_OFF_OSC, 32'h0);
        repeat (3) @(posedge clk);
        check(33'(oread), 33'(opin));
        check(33'(osc_pins_input), 33'h0);
        $display("Test oscillator pins done");
        stop_test();
    end
endmodule
